// [core/tff_pkg.sv]
// Constants and types shared by the telemetry frame formatter.
package tff_pkg;
    localparam int WORD_W = 12;
    localparam int BYTE_W = 8;
    localparam int SLOT_W = 5;
    localparam int FRAME_WORDS = 32;
    localparam int FIFO_DEPTH = 4;
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 5'h02;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h1F;
    localparam logic [SLOT_W-1:0] SLOT_X = 5'h03;
    localparam logic [SLOT_W-1:0] SLOT_Y = 5'h04;
    localparam logic [SLOT_W-1:0] SLOT_EXPO = 5'h1C;
    localparam logic [SLOT_W-1:0] SLOT_TYPE = 5'h1F;
    localparam logic [1:0] PIXEL_PHASE = 2'h2;
    localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
    localparam logic [BYTE_W-1:0] TYPE_EMPTY = 8'h00;
    localparam logic [BYTE_W-1:0] TYPE_NOPIX = 8'h01;
    localparam logic [BYTE_W-1:0] TYPE_PIX = 8'h02;
    localparam real MHZ = 250.0;
    localparam real FIRST_LOAD_US = 63.0;
    localparam int FIRST_LOAD_CYC = int'($floor(FIRST_LOAD_US * MHZ));
    typedef enum logic [1:0] {
        TFF_SRC_ZERO,
        TFF_SRC_PIXEL,
        TFF_SRC_EXP,
        TFF_SRC_INT
    } tff_src_t;
    typedef enum {
        TFF_EMPTY,
        TFF_NOPIX,
        TFF_PIX
    } tff_ftype_t;
endpackage

// [core/tff_fifo.sv]
// Small valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
`default_nettype none
module tff_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;
    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    always_ff @(posedge mclk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule
`default_nettype wire

// [core/telemetry_frame_formatter.sv]
// Telemetry frame formatter: builds words 2..31 of each frame.
// Behaviour
// R1: Telemetry supplies words 0 and 1; formatter sources word 2 onward.
// R2: Word 2 sits in the holding register within 63.0 us of frame start.
// R3: Frame starts on rising level of frame_start_sync.
// R4: Frame start realigns word position, discarding prior position state.
// R5: A rising word_strobe marks a word period start, then next word loads.
// R6: Each word period finishes loading the next frame word.
// R7: A running slot counter tracks position within the frame.
// R8: Each word byte comes from pixel bus, experiment bus or internal value.
// R9: A programmable per-slot schedule selects each slot's source.
// R10: Every sequencer write goes to the holding register.
// R11: Pixel bytes in slots 2,6,...,30, low eight bits, upper four zero.
// R12: Slots with no assigned content are all zeros.
// R13: Slot 3 X, 4 Y, 28 exposure/filter, 31 frame type, low byte each.
// R14: Holding register drives output bus on word_strobe leading edge; here it enters the FIFO then unless full, and reaches telemetryBus when popped.
// R15: Status lines pick empty, picture-no-pixels or picture-with-pixels.
// R16: Empty frames fill only slots 28 and 31.
// R17: A frame has 32 twelve-bit words.
`timescale 1ns/1ps
`default_nettype none
module telemetry_frame_formatter
    import tff_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic frame_start_sync,
    input wire logic word_strobe,
    input wire logic converter_enable,
    input wire logic pixel_window_active,
    input wire logic [BYTE_W-1:0] pixelBus,
    input wire logic [BYTE_W-1:0] experimentBus,
    input wire logic [BYTE_W-1:0] pixelX,
    input wire logic [BYTE_W-1:0] pixelY,
    input wire logic schedWe,
    input wire logic [SLOT_W-1:0] schedAddr,
    input wire logic [1:0] schedSrc,
    input wire logic [BYTE_W-1:0] internalByte,
    output logic pixelRead,
    output logic [WORD_W-1:0] telemetryBus,
    output logic telemetryValid,
    input wire logic telemetryReady,
    output logic [SLOT_W-1:0] slotPos
);
    logic fssPrev_reg;
    logic wsPrev_reg;
    logic frameStart;
    logic wordStart;
    logic [SLOT_W-1:0] slot_reg;
    logic [SLOT_W-1:0] slot_next;
    logic inFrame_reg;
    logic [WORD_W-1:0] hold_reg;
    logic [WORD_W-1:0] hold_next;
    logic holdLoad;
    tff_ftype_t ftype_reg;
    tff_ftype_t ftype_next;
    tff_src_t sched_reg [FRAME_WORDS];
    tff_src_t src;
    logic [BYTE_W-1:0] intReg_reg;
    logic fifoReady;
    logic [WORD_W-1:0] fifoOut;
    logic [BYTE_W-1:0] typeByte;
    logic loaded_reg;
    int loadWait_reg;
    logic pushWord;
    logic [SLOT_W:0] pushCount_reg;

    assign frameStart = frame_start_sync && !fssPrev_reg; // R3
    assign wordStart = word_strobe && !wsPrev_reg; // R5
    assign slotPos = slot_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fssPrev_reg <= 1'b0;
            wsPrev_reg <= 1'b0;
        end else begin
            fssPrev_reg <= frame_start_sync;
            wsPrev_reg <= word_strobe;
        end
    end

    // The slot held in the register is the one to be sent at the next strobe.
    always_comb begin
        slot_next = slot_reg;
        if (frameStart) begin
            slot_next = FIRST_SLOT; // R1 R4
        end else if (wordStart && inFrame_reg && slot_reg != LAST_SLOT) begin
            slot_next = slot_reg + 1'b1; // R7
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            slot_reg <= FIRST_SLOT;
            inFrame_reg <= 1'b0;
        end else begin
            slot_reg <= slot_next;
            if (frameStart) begin
                inFrame_reg <= 1'b1; // R4
            end else if (wordStart && slot_reg == LAST_SLOT) begin // R17
                inFrame_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        ftype_next = TFF_EMPTY;
        case ({converter_enable, pixel_window_active})
            2'b10: ftype_next = TFF_NOPIX; // R15
            2'b11: ftype_next = TFF_PIX; // R15
            default: ftype_next = TFF_EMPTY;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ftype_reg <= TFF_EMPTY;
        end else if (frameStart) begin
            ftype_reg <= ftype_next; // R15
        end
    end

    // Default schedule matches the fixed layout; software may rewrite any slot.
    generate
        for (genvar i = 0; i < FRAME_WORDS; i++) begin : g_sched
            localparam logic [SLOT_W-1:0] SI = SLOT_W'(i);
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    if (SI >= FIRST_SLOT && SI[1:0] == PIXEL_PHASE) begin
                        sched_reg[i] <= TFF_SRC_PIXEL; // R11
                    end else if (SI == SLOT_EXPO) begin
                        sched_reg[i] <= TFF_SRC_EXP;
                    end else if (SI == SLOT_X || SI == SLOT_Y || SI == SLOT_TYPE) begin
                        sched_reg[i] <= TFF_SRC_INT;
                    end else begin
                        sched_reg[i] <= TFF_SRC_ZERO; // R12
                    end
                end else if (schedWe && schedAddr == SI) begin
                    sched_reg[i] <= tff_src_t'(schedSrc); // R9
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            intReg_reg <= '0;
        end else begin
            intReg_reg <= internalByte;
        end
    end

    always_comb begin
        case (ftype_reg)
            TFF_NOPIX: typeByte = TYPE_NOPIX;
            TFF_PIX: typeByte = TYPE_PIX;
            default: typeByte = TYPE_EMPTY;
        endcase
    end

    // Source selection for the slot now pending.
    assign src = sched_reg[slot_reg];

    always_comb begin
        hold_next = WORD_ZERO; // R12
        if (ftype_reg == TFF_EMPTY && slot_reg != SLOT_EXPO && slot_reg != SLOT_TYPE) begin
            hold_next = WORD_ZERO; // R16
        end else if (slot_reg == SLOT_X && src == TFF_SRC_INT) begin
            hold_next = {4'h0, pixelX}; // R13
        end else if (slot_reg == SLOT_Y && src == TFF_SRC_INT) begin
            hold_next = {4'h0, pixelY}; // R13
        end else if (slot_reg == SLOT_TYPE && src == TFF_SRC_INT) begin
            hold_next = {4'h0, typeByte}; // R13
        end else begin
            case (src)
                TFF_SRC_PIXEL: begin
                    if (ftype_reg == TFF_PIX) begin
                        hold_next = {4'h0, pixelBus}; // R8 R11
                    end
                end
                TFF_SRC_EXP: hold_next = {4'h0, experimentBus}; // R8 R13
                TFF_SRC_INT: hold_next = {4'h0, intReg_reg}; // R8
                default: hold_next = WORD_ZERO;
            endcase
        end
    end

    // Reload one cycle after each slot change, well inside the word period.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            loaded_reg <= 1'b0;
        end else if (frameStart || wordStart) begin
            loaded_reg <= 1'b0;
        end else if (inFrame_reg) begin
            loaded_reg <= 1'b1;
        end
    end
    assign holdLoad = inFrame_reg && !loaded_reg && !frameStart && !wordStart; // R2 R6

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_reg <= WORD_ZERO;
        end else if (holdLoad) begin
            hold_reg <= hold_next; // R10
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pixelRead <= 1'b0;
        end else begin
            pixelRead <= holdLoad && src == TFF_SRC_PIXEL && ftype_reg == TFF_PIX;
        end
    end

    assign pushWord = wordStart && inFrame_reg && loaded_reg; // R14

    // Word leaves on the strobe edge; the FIFO absorbs up to FIFO_DEPTH words of encoder back-pressure, later words are dropped.
    tff_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inValid(pushWord), // R14
        .inReady(fifoReady),
        .inData(hold_reg),
        .outValid(telemetryValid),
        .outReady(telemetryReady),
        .outData(fifoOut)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            telemetryBus <= WORD_ZERO;
        end else if (telemetryValid && telemetryReady) begin
            telemetryBus <= fifoOut; // R14
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || frameStart) begin
            loadWait_reg <= 0;
        end else if (inFrame_reg && slot_reg == FIRST_SLOT && !loaded_reg) begin
            loadWait_reg <= loadWait_reg + 1;
        end
    end

    firstLoad_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        loadWait_reg <= FIRST_LOAD_CYC)
        else $error("third word not loaded in time");
    realign_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4
        frameStart |=> slot_reg == FIRST_SLOT && inFrame_reg)
        else $error("frame start did not realign slot");
    slotStep_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
        wordStart && !frameStart && inFrame_reg && slot_reg != LAST_SLOT
        |=> slot_reg == $past(slot_reg) + 5'h01)
        else $error("slot counter did not advance");
    holdFill_a: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        wordStart && !frameStart && inFrame_reg && slot_reg != LAST_SLOT
        |=> ##1 loaded_reg)
        else $error("holding register not reloaded");
    upperZero_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
        hold_reg[WORD_W-1:BYTE_W] == 4'h0)
        else $error("upper bits of word not zero");
    emptyZero_a: assert property (@(posedge mclk) disable iff (sys_rst) // R16
        holdLoad && ftype_reg == TFF_EMPTY && slot_reg != SLOT_EXPO
        && slot_reg != SLOT_TYPE |=> hold_reg == WORD_ZERO)
        else $error("empty frame word not zero");
    typeWord_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
        holdLoad && slot_reg == SLOT_TYPE && src == TFF_SRC_INT
        |=> hold_reg == {4'h0, typeByte})
        else $error("frame type word wrong");
    zeroSlot_a: assert property (@(posedge mclk) disable iff (sys_rst) // R12
        holdLoad && src == TFF_SRC_ZERO |=> hold_reg == WORD_ZERO)
        else $error("unassigned slot not zero");
    pushOnEdge_a: assert property (@(posedge mclk) disable iff (sys_rst) // R14
        wordStart && inFrame_reg && loaded_reg && fifoReady
        |=> telemetryValid)
        else $error("word not pushed on strobe");

    // Words pushed since the last frame start, for the frame length check.
    always_ff @(posedge mclk) begin
        if (sys_rst || frameStart) begin
            pushCount_reg <= '0;
        end else if (pushWord) begin
            pushCount_reg <= pushCount_reg + 1'b1;
        end
    end
    pixType_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15
        frameStart && converter_enable && pixel_window_active |=> ftype_reg == TFF_PIX)
        else $error("picture frame type not selected");
    emptyType_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15
        frameStart && !converter_enable |=> ftype_reg == TFF_EMPTY)
        else $error("empty frame type not selected");
    xWord_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
        holdLoad && ftype_reg != TFF_EMPTY && slot_reg == SLOT_X && src == TFF_SRC_INT
        |=> hold_reg == {4'h0, $past(pixelX)})
        else $error("pixel address word wrong");
    pixelWord_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
        holdLoad && ftype_reg == TFF_PIX && src == TFF_SRC_PIXEL
        |=> hold_reg == {4'h0, $past(pixelBus)} && pixelRead)
        else $error("pixel word or read pulse wrong");
    busUpdate_a: assert property (@(posedge mclk) disable iff (sys_rst) // R14
        telemetryValid && telemetryReady |=> telemetryBus == $past(fifoOut))
        else $error("telemetry bus not updated on pop");
    idleHold_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        !inFrame_reg && !frameStart |=> slot_reg == $past(slot_reg))
        else $error("slot moved outside a frame");
    frameLength_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
        pushCount_reg <= (SLOT_W+1)'(FRAME_WORDS) - (SLOT_W+1)'(FIRST_SLOT))
        else $error("too many words in one frame");
endmodule
`default_nettype wire

// [tb/tff_encoder_model.sv]
// Model of the telemetry encoder that makes frame and word sync and takes words.
`timescale 1ns/1ps
`default_nettype none
module tff_encoder_model
    import tff_pkg::*;
(
    input wire logic mclk,
    output logic frame_start_sync,
    output logic word_strobe,
    output logic telemetryReady,
    input wire logic telemetryValid,
    input wire logic [WORD_W-1:0] telemetryBus
);
    logic readyEn = 1'b1;
    logic popPend = 1'b0;
    logic [WORD_W-1:0] got[$];
    initial begin
        frame_start_sync = 1'b0;
        word_strobe = 1'b0;
    end
    assign telemetryReady = readyEn;
    // The bus changes at the pop edge, so it is taken one edge later.
    always @(posedge mclk) begin
        if (popPend) begin
            got.push_back(telemetryBus);
        end
        popPend <= telemetryValid && telemetryReady;
    end
    task automatic frame_start();
        @(negedge mclk) frame_start_sync = 1'b1;
        repeat (2) @(negedge mclk);
        frame_start_sync = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic strobes(input int n);
        repeat (n) begin
            word_strobe = 1'b1;
            repeat (2) @(negedge mclk);
            word_strobe = 1'b0;
            repeat (6) @(negedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench of the telemetry frame formatter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tff_pkg::*;
    logic mclk, sys_rst, converter_enable, pixel_window_active, schedWe;
    logic frame_start_sync, word_strobe, telemetryReady, telemetryValid, pixelRead;
    logic [BYTE_W-1:0] pixelBus, experimentBus, pixelX, pixelY, internalByte;
    logic [SLOT_W-1:0] schedAddr, slotPos;
    logic [1:0] schedSrc;
    logic [WORD_W-1:0] telemetryBus;
    logic [1:0] sched[32];
    int badCount = 0;
    int checks = 0;
    telemetry_frame_formatter dut (.mclk(mclk), .sys_rst(sys_rst),
        .frame_start_sync(frame_start_sync), .word_strobe(word_strobe),
        .converter_enable(converter_enable), .pixel_window_active(pixel_window_active),
        .pixelBus(pixelBus), .experimentBus(experimentBus), .pixelX(pixelX),
        .pixelY(pixelY), .schedWe(schedWe), .schedAddr(schedAddr), .schedSrc(schedSrc),
        .internalByte(internalByte), .pixelRead(pixelRead), .telemetryBus(telemetryBus),
        .telemetryValid(telemetryValid), .telemetryReady(telemetryReady),
        .slotPos(slotPos));
    tff_encoder_model enc (.mclk(mclk), .frame_start_sync(frame_start_sync),
        .word_strobe(word_strobe), .telemetryReady(telemetryReady),
        .telemetryValid(telemetryValid), .telemetryBus(telemetryBus));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // The converter steps to its next pixel on each read pulse.
    always @(negedge mclk) begin
        if (pixelRead === 1'b1) begin
            pixelBus <= pixelBus + 8'h01;
        end
    end
    task automatic check_value(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (badCount == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [WORD_W-1:0] exp_word(input int s, input int t, input logic [7:0] p);
        logic [7:0] b;
        b = 8'h00;
        case (sched[s])
            2'h1: b = (t == 2) ? p : 8'h00;
            2'h2: b = experimentBus;
            2'h3: b = (s == 3) ? pixelX : (s == 4) ? pixelY : (s != 31) ? internalByte :
                (t == 0) ? TYPE_EMPTY : (t == 1) ? TYPE_NOPIX : TYPE_PIX;
            default: b = 8'h00;
        endcase
        if (t == 0 && s != 28 && s != 31) b = 8'h00;
        return {4'h0, b};
    endfunction
    task automatic set_type(input int t);
        converter_enable = (t != 0);
        pixel_window_active = (t == 2);
    endtask
    task automatic run_frame(input int t, input logic [7:0] base);
        int n;
        n = 0;
        set_type(t);
        pixelBus = base;
        enc.got.delete();
        enc.frame_start();
        check_value({7'h00, slotPos}, 12'h002);
        enc.strobes(30);
        repeat (8) @(negedge mclk);
        check_value(WORD_W'(enc.got.size()), 12'h01e);
        for (int s = 2; s < 32 && s - 2 < enc.got.size(); s++) begin
            check_value(enc.got[s - 2], exp_word(s, t, base + n[7:0]));
            if (sched[s] == 2'h1 && t == 2) n++;
        end
    endtask
    task automatic sched_write(input int a, input logic [1:0] src);
        schedWe = 1'b1;
        schedAddr = a[SLOT_W-1:0];
        schedSrc = src;
        sched[a] = src;
        @(negedge mclk);
        schedWe = 1'b0;
        @(negedge mclk);
    endtask
    task automatic scenario_no_frame();
        enc.strobes(3);
        repeat (4) @(negedge mclk);
        check_value({11'h000, telemetryValid}, 12'h000);
    endtask
    task automatic scenario_types();
        for (int t = 0; t < 3; t++) run_frame(t, 8'h40);
    endtask
    task automatic scenario_realign();
        set_type(2);
        enc.frame_start();
        enc.strobes(9);
        run_frame(2, 8'h80);
        enc.got.delete();
        enc.strobes(2);
        repeat (4) @(negedge mclk);
        check_value(WORD_W'(enc.got.size()), 12'h000);
    endtask
    task automatic scenario_schedule();
        internalByte = 8'ha5;
        sched_write(5, 2'h3);
        sched_write(7, 2'h2);
        sched_write(2, 2'h0);
        run_frame(2, 8'h10);
    endtask
    task automatic scenario_stall();
        set_type(1);
        enc.got.delete();
        enc.readyEn = 1'b0;
        enc.frame_start();
        enc.strobes(6);
        check_value({11'h000, telemetryValid}, 12'h001);
        enc.readyEn = 1'b1;
        repeat (12) @(negedge mclk);
        check_value(WORD_W'(enc.got.size()), 12'h004);
        for (int s = 2; s < 6 && s - 2 < enc.got.size(); s++) begin
            check_value(enc.got[s - 2], exp_word(s, 1, 8'h00));
        end
        check_value({11'h000, telemetryValid}, 12'h000);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        report_and_stop();
    end
    initial begin
        for (int s = 0; s < 32; s++) begin
            sched[s] = (s % 4 == 2) ? 2'h1 : (s == 28) ? 2'h2 : (s == 3 || s == 4 || s == 31) ?
                2'h3 : 2'h0;
        end
        sys_rst = 1'b1;
        set_type(0);
        schedWe = 1'b0;
        schedAddr = 5'h00;
        schedSrc = 2'h0;
        pixelBus = 8'h00;
        experimentBus = 8'hb7;
        pixelX = 8'h3c;
        pixelY = 8'h5a;
        internalByte = 8'h00;
        repeat (20) @(negedge mclk);
        check_value({11'h000, telemetryValid}, 12'h000);
        check_value({7'h00, slotPos}, 12'h002);
        check_value(telemetryBus, 12'h000);
        sys_rst = 1'b0;
        scenario_no_frame();
        scenario_types();
        scenario_realign();
        scenario_schedule();
        scenario_stall();
        report_and_stop();
    end
endmodule
`default_nettype wire
